/* File: design/fsf_filter.sv */
/*
 feedback sampling filter: startup sequencing, per-switching-cycle
 feedback sampling, low-pass / notch filtering and mode selection,
 with an apb register slave.
 assumes all inputs synchronous to clk_sys_i; the feedback sample is
 already converted and valid when blank_end_i pulses.
*/
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fsf_cfg.svh"

module fsf_filter
    import fsf_pkg::*;
#(
    parameter int FB_W     = 12,
    parameter int CNT_W    = 10,
    parameter int OPC_CYC  = `FSF_OPC_CYC,
    parameter int SOFT_CYC = `FSF_SOFT_CYC
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [7:0]       paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    input  wire logic [FB_W-1:0]  fb_sample_i,
    input  wire logic             blank_end_i,
    input  wire logic [FB_W-1:0]  vin_est_i,
    input  wire logic [7:0]       temp_est_i,
    input  wire logic [FB_W-1:0]  vout_est_i,
    input  wire logic             protect_i,
    input  wire logic             line_lock_i,
    input  wire logic             dc_input_i,
    input  wire logic             halfsine_tick_i,
    input  wire logic             burst_pulse_i,
    input  wire logic             burst_sleep_i,
    output logic      [2:0]       phase_o,
    output logic      [1:0]       mode_o,
    output logic                  notch_en_o,
    output logic      [FB_W-1:0]  filtered_feedback_value_o,
    output logic      [9:0]       on_time_o,
    output logic      [3:0]       valley_o,
    output logic      [9:0]       min_switch_period_o,
    output logic      [5:0]       burst_pulse_count_o,
    output logic                  feedback_pullup_en_o,
    output logic      [3:0]       feedback_pullup_select_o
);

    localparam int SUM_W = FB_W + CNT_W;

    if (FB_W < 10 || FB_W > 16 || CNT_W < 4 || OPC_CYC < 2
        || SOFT_CYC < 1) begin : g_chk
        $error("fsf_filter: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, registered answer

    logic [31:0] ctrl_r;
    logic [31:0] start_r;
    logic [31:0] vinlim_r;
    logic [31:0] thr_r;
    logic [31:0] templim_r;
    logic        wr_go;
    logic        rd_go;
    logic        map_hit;
    logic [31:0] rd_val;

    assign wr_go = psel_i & penable_i & pready_o & pwrite_i;
    assign rd_go = psel_i & penable_i & ~pready_o;

    always_comb begin
        map_hit = 1'b1;
        rd_val  = 32'h0000_0000;
        unique case (paddr_i)
            `FSF_OFS_CTRL:    rd_val = ctrl_r;
            `FSF_OFS_START:   rd_val = start_r;
            `FSF_OFS_VINLIM:  rd_val = vinlim_r;
            `FSF_OFS_THR:     rd_val = thr_r;
            `FSF_OFS_TEMPLIM: rd_val = templim_r;
            `FSF_OFS_STATUS: begin
                rd_val[2:0] = phase_o;
                rd_val[`FSF_ST_MODE_LSB +: 2] = mode_o;
                rd_val[`FSF_ST_NOTCH_BIT] = notch_en_o;
            end
            `FSF_OFS_FILT:    rd_val[FB_W-1:0] = filtered_feedback_value_o;
            `FSF_OFS_PARAM: begin
                rd_val[9:0] = on_time_o;
                rd_val[`FSF_PAR_VAL_LSB +: 4] = valley_o;
                rd_val[`FSF_PAR_BST_LSB +: 6] = burst_pulse_count_o;
            end
            default:          map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= rd_go;
            pslverr_o <= rd_go & ~map_hit;
            prdata_o  <= (rd_go & ~pwrite_i & map_hit) ? rd_val
                                                       : 32'h0000_0000;
        end
    end

    // read-only and unmapped words ignore writes
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r    <= `FSF_CTRL_RST;
            start_r   <= `FSF_START_RST;
            vinlim_r  <= `FSF_VINLIM_RST;
            thr_r     <= `FSF_THR_RST;
            templim_r <= `FSF_TEMPLIM_RST;
        end else if (wr_go) begin
            unique case (paddr_i)
                `FSF_OFS_CTRL:    ctrl_r    <= pwdata_i;
                `FSF_OFS_START:   start_r   <= pwdata_i;
                `FSF_OFS_VINLIM:  vinlim_r  <= pwdata_i;
                `FSF_OFS_THR:     thr_r     <= pwdata_i;
                `FSF_OFS_TEMPLIM: templim_r <= pwdata_i;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // startup sequencing

    fsf_phase_e  phase_r;
    logic [31:0] soft_cnt_r;
    logic        start_en;
    logic        pre_ok;

    assign start_en = ctrl_r[`FSF_CTRL_EN_BIT];
    assign pre_ok   = (vin_est_i >= vinlim_r[FB_W-1:0])
                    & (vin_est_i <= vinlim_r[`FSF_HI_LSB +: FB_W])
                    & (temp_est_i <= templim_r[7:0]);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_r    <= FSF_IDLE;
            soft_cnt_r <= 32'h0000_0000;
        end else if (protect_i && phase_r != FSF_IDLE) begin
            phase_r <= FSF_FAULT;
        end else begin
            unique case (phase_r)
                FSF_IDLE: if (start_en && pre_ok) begin     // [R1]
                    phase_r    <= FSF_SOFT;
                    soft_cnt_r <= 32'h0000_0000;
                end
                FSF_SOFT: begin                             // [R2]
                    soft_cnt_r <= soft_cnt_r + 32'h0000_0001;
                    if (soft_cnt_r == 32'(SOFT_CYC - 1))
                        phase_r <= FSF_CHARGE;
                end
                FSF_CHARGE:                                 // [R2]
                    if (vout_est_i >= start_r[FB_W-1:0])
                        phase_r <= FSF_REG;                 // [R3]
                FSF_REG: if (!start_en) phase_r <= FSF_IDLE;
                // auto-restart once protection clears
                FSF_FAULT: phase_r <= FSF_IDLE;
                default: phase_r <= FSF_IDLE;
            endcase
        end
    end

    logic in_reg;
    assign in_reg = (phase_r == FSF_REG);

    ////////////////////////////////////////////////////////////////////
    // operation cycle: free running, or half-sine when locked

    logic [31:0] opc_cnt_r;
    logic        opc_tick_r;
    logic        ac_lock;

    assign ac_lock = line_lock_i & ~dc_input_i;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            opc_cnt_r  <= 32'h0000_0000;
            opc_tick_r <= 1'b0;
        end else begin
            opc_tick_r <= 1'b0;
            if (ac_lock ? halfsine_tick_i                    // [R13]
                        : (opc_cnt_r >= 32'(OPC_CYC - 1))) begin
                opc_cnt_r  <= 32'h0000_0000;
                opc_tick_r <= 1'b1;
            end else begin
                opc_cnt_r <= opc_cnt_r + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // notch enable after lock or dc held past the blanking count

    fsf_mode_e  mode_r;
    logic [7:0] blk_cnt_r;
    logic       notch_r;
    logic       cond;

    assign cond = in_reg & (mode_r != FSF_BURST) & (ac_lock | dc_input_i);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blk_cnt_r <= 8'h00;
            notch_r   <= 1'b0;
        end else if (!cond) begin
            blk_cnt_r <= 8'h00;
            notch_r   <= 1'b0;                              // [R10]
        end else if (opc_tick_r) begin
            if (blk_cnt_r > start_r[`FSF_START_BLK_LSB +: 8])
                notch_r <= 1'b1;                            // [R10]
            else
                blk_cnt_r <= blk_cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sampling, low-pass and notch filtering

    logic [FB_W-1:0]  filt_r;
    logic             take;
    logic signed [FB_W:0] lp_diff;
    logic signed [FB_W:0] lp_next;
    logic [SUM_W-1:0] sum_r;
    logic [CNT_W-1:0] cnt_r;
    logic             div_busy_r;
    logic [7:0]       div_step_r;
    logic [SUM_W-1:0] div_num_r;
    logic [CNT_W-1:0] div_den_r;
    logic [CNT_W-1:0] div_rem_r;
    logic [FB_W-1:0]  div_q_r;
    logic [CNT_W:0]   rem_sh;

    // burst filters only while pulses go out; sleep samples are noise
    assign take = in_reg & blank_end_i                      // [R4] [R9]
                & ((mode_r != FSF_BURST) | burst_pulse_i);  // [R12]
    assign lp_diff = $signed({1'b0, fb_sample_i})
                   - $signed({1'b0, filt_r});
    assign lp_next = $signed({1'b0, filt_r})
                   + (lp_diff >>> `FSF_LP_SHIFT);
    assign rem_sh  = {div_rem_r, div_num_r[SUM_W-1]};

    // notch: mean over one operation cycle, a comb with zeros at the
    // ripple or dither tone since the cycle tracks its period
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sum_r <= '0;
            cnt_r <= '0;
        end else if (!notch_r || opc_tick_r) begin
            sum_r <= '0;                                    // [R11]
            cnt_r <= '0;
        end else if (take && cnt_r != '1) begin
            sum_r <= sum_r + SUM_W'(fb_sample_i);           // [R11]
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // serial divider trades latency for area; result lands well
    // inside the next operation cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_busy_r <= 1'b0;
            div_step_r <= 8'h00;
            div_num_r  <= '0;
            div_den_r  <= '0;
            div_rem_r  <= '0;
            div_q_r    <= '0;
        end else if (notch_r && opc_tick_r && cnt_r != '0) begin
            div_busy_r <= 1'b1;
            div_step_r <= 8'(SUM_W);
            div_num_r  <= sum_r;
            div_den_r  <= cnt_r;
            div_rem_r  <= '0;
            div_q_r    <= '0;
        end else if (div_busy_r) begin
            div_num_r  <= {div_num_r[SUM_W-2:0], 1'b0};
            div_step_r <= div_step_r - 8'h01;
            div_busy_r <= (div_step_r != 8'h01);
            if (rem_sh >= {1'b0, div_den_r}) begin
                div_rem_r <= CNT_W'(rem_sh - {1'b0, div_den_r});
                div_q_r   <= {div_q_r[FB_W-2:0], 1'b1};
            end else begin
                div_rem_r <= rem_sh[CNT_W-1:0];
                div_q_r   <= {div_q_r[FB_W-2:0], 1'b0};
            end
        end
    end

    // one state for both filters, so a switch never steps the output
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            filt_r <= '0;
        end else if (!(notch_r && cond)) begin
            if (take)
                filt_r <= lp_next[FB_W-1:0];                // [R4] [R14]
        end else if (div_busy_r && div_step_r == 8'h01) begin
            filt_r <= (rem_sh >= {1'b0, div_den_r})          // [R14]
                    ? {div_q_r[FB_W-2:0], 1'b1}
                    : {div_q_r[FB_W-2:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode selection and switching parameters, per operation cycle

    logic [3:0] vdiv_r;
    logic [3:0] valley_nxt;

    assign valley_nxt = 4'hF - filt_r[FB_W-1 -: 4];

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_r              <= FSF_VALLEY;
            on_time_o           <= 10'h000;
            min_switch_period_o <= 10'h3FF;
            burst_pulse_count_o <= 6'h00;
        end else if (in_reg && opc_tick_r) begin            // [R5]
            if (filt_r < thr_r[FB_W-1:0])
                mode_r <= FSF_BURST;
            else if (filt_r < thr_r[`FSF_HI_LSB +: FB_W])
                mode_r <= FSF_DCM;
            else
                mode_r <= FSF_VALLEY;
            on_time_o <= filt_r[FB_W-1 -: 10];              // [R3] [R5]
            if (mode_r != FSF_BURST)
                min_switch_period_o <= ~filt_r[FB_W-1 -: 10]; // [R6]
            else
                burst_pulse_count_o <= filt_r[FB_W-1 -: 6];   // [R6]
        end
    end

    // valley number moves slower than on-time to stay steady
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vdiv_r   <= 4'h0;
            valley_o <= 4'h1;
        end else if (in_reg && opc_tick_r && mode_r != FSF_BURST) begin
            if (vdiv_r >= 4'(`FSF_VALLEY_DIV - 1)) begin    // [R6]
                vdiv_r   <= 4'h0;
                valley_o <= valley_nxt;                     // [R5]
            end else begin
                vdiv_r <= vdiv_r + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pull-up control and status outputs

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            feedback_pullup_en_o      <= 1'b0;
            feedback_pullup_select_o  <= 4'h0;
            phase_o                   <= 3'b000;
            mode_o                    <= 2'b00;
            notch_en_o                <= 1'b0;
            filtered_feedback_value_o <= '0;
        end else begin
            feedback_pullup_en_o <= (phase_r != FSF_IDLE)
                & ~((mode_r == FSF_BURST) & burst_sleep_i); // [R8]
            feedback_pullup_select_o <= ctrl_r[`FSF_CTRL_PU_LSB +: 4]; // [R7]
            phase_o                   <= phase_r;
            mode_o                    <= mode_r;
            notch_en_o                <= notch_r & cond;
            filtered_feedback_value_o <= filt_r;
        end
    end

endmodule

/* File: design/fsf_cfg.svh */
/*
 constants of the feedback sampling filter: register offsets, field
 positions, reset values and timing counts.
 assumes a 125 MHz system clock and 32-bit apb data.
*/
// Function
// (R1) start only when input and temperature are in limits
// (R2) soft start, then charge output to target
// (R3) no protection at startup end: enter regulation
// (R4) regulated mode samples and filters feedback
// (R5) filtered value picks mode and switching parameters
// (R6) each parameter has its own update rate
// (R7) pull-up resistance selectable by configuration
// (R8) pull-up off during burst sleep
// (R9) sample at end of sense blanking
// (R10) notch after lock or dc held past blanking
// (R11) notch rejects line ripple or dither tone
// (R12) burst: low-pass only while pulses issued
// (R13) operation cycle default, or half-sine when locked
// (R14) filter state carried over on switches
`ifndef FSF_CFG_SVH
`define FSF_CFG_SVH

`define FSF_CLK_PERIOD_NS   8
`define FSF_OPC_PERIOD_NS   9823000
`define FSF_OPC_CYC         ((`FSF_OPC_PERIOD_NS) / (`FSF_CLK_PERIOD_NS))
`define FSF_SOFT_PERIOD_NS  2000000
`define FSF_SOFT_CYC        ((`FSF_SOFT_PERIOD_NS) / (`FSF_CLK_PERIOD_NS))

`define FSF_OFS_CTRL        8'h00
`define FSF_OFS_START       8'h04
`define FSF_OFS_VINLIM      8'h08
`define FSF_OFS_THR         8'h0C
`define FSF_OFS_TEMPLIM     8'h10
`define FSF_OFS_STATUS      8'h14
`define FSF_OFS_FILT        8'h18
`define FSF_OFS_PARAM       8'h1C

`define FSF_CTRL_EN_BIT     0
`define FSF_CTRL_PU_LSB     4
`define FSF_START_BLK_LSB   16
`define FSF_HI_LSB          16
`define FSF_ST_MODE_LSB     4
`define FSF_ST_NOTCH_BIT    8
`define FSF_PAR_VAL_LSB     12
`define FSF_PAR_BST_LSB     16

`define FSF_CTRL_RST        32'h0000_0000
`define FSF_START_RST       32'h0004_0C00
`define FSF_VINLIM_RST      32'h0E00_0200
`define FSF_THR_RST         32'h0400_0100
`define FSF_TEMPLIM_RST     32'h0000_00C0

`define FSF_LP_SHIFT        3
`define FSF_VALLEY_DIV      2

`endif

/* File: design/fsf_pkg.sv */
/*
 types of the feedback sampling filter.
 assumes fsf_cfg.svh holds all numeric constants.
*/
package fsf_pkg;

    typedef enum logic [2:0] {
        FSF_IDLE   = 3'b000,
        FSF_SOFT   = 3'b001,
        FSF_CHARGE = 3'b010,
        FSF_REG    = 3'b011,
        FSF_FAULT  = 3'b100
    } fsf_phase_e;

    typedef enum logic [1:0] {
        FSF_VALLEY = 2'b00,
        FSF_DCM    = 2'b01,
        FSF_BURST  = 2'b10
    } fsf_mode_e;

endpackage

/* File: sim/fsf_opto_model.sv */
/*
 optocoupler feedback network model on the feedback pin.
 assumes the device pull-up feeds the pin; level_i is the target level.
*/
`timescale 1ns/1ps

module fsf_opto_model (
    input  wire logic        clk_i,
    input  wire logic        pullup_en_i,
    input  wire logic [11:0] level_i,
    output logic      [11:0] fb_o
);
    // no pull-up: the transistor sinks the pin to ground
    always_ff @(posedge clk_i) begin
        fb_o <= pullup_en_i ? level_i : 12'h000;
    end
endmodule

/* File: sim/fsf_filter_asserts.sv */
/*
 port checker of the feedback sampling filter.
 assumes it is bound to fsf_filter and sees only its ports.
*/
`timescale 1ns/1ps

module fsf_filter_asserts
    import fsf_pkg::*;
#(
    parameter int FB_W = 12
) (
    input wire logic            clk_sys_i,
    input wire logic            reset_n_i,
    input wire logic            psel_i,
    input wire logic            penable_i,
    input wire logic [7:0]      paddr_i,
    input wire logic            pready_o,
    input wire logic            pslverr_o,
    input wire logic            blank_end_i,
    input wire logic            burst_pulse_i,
    input wire logic            burst_sleep_i,
    input wire logic            line_lock_i,
    input wire logic            dc_input_i,
    input wire logic [FB_W-1:0] fb_sample_i,
    input wire logic [2:0]      phase_o,
    input wire logic [1:0]      mode_o,
    input wire logic            notch_en_o,
    input wire logic [FB_W-1:0] filtered_feedback_value_o,
    input wire logic            feedback_pullup_en_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////////
    a_ready_wait: assert property ($rose(psel_i && penable_i) |=> pready_o)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property ($rose(psel_i && penable_i)
        && paddr_i > 8'h1C |=> pslverr_o && pready_o)
        else $error("no error on unmapped address");
    a_err_mapped: assert property ($rose(psel_i && penable_i)
        && paddr_i <= 8'h1C |=> !pslverr_o)
        else $error("error on mapped address");
    a_soft_entry: assert property ($changed(phase_o)
        && phase_o == FSF_SOFT |-> $past(phase_o) == FSF_IDLE)
        else $error("soft start not from idle");
    a_charge_entry: assert property ($changed(phase_o)
        && phase_o == FSF_CHARGE |-> $past(phase_o) == FSF_SOFT)
        else $error("charging not after soft start");
    a_reg_entry: assert property ($changed(phase_o)
        && phase_o == FSF_REG |-> $past(phase_o) == FSF_CHARGE)
        else $error("regulation not after charging");
    a_notch_gate: assert property (notch_en_o
        |-> phase_o == FSF_REG && mode_o != FSF_BURST)
        else $error("notch outside regulated non-burst");
    a_notch_drop: assert property ((!line_lock_i && !dc_input_i)[*2]
        |=> !notch_en_o)
        else $error("notch held without lock or dc");
    a_lp_step: assert property (blank_end_i && burst_pulse_i
        && phase_o == FSF_REG
        && {1'b0, fb_sample_i} >= {1'b0, filtered_feedback_value_o} + 64
        ##1 !notch_en_o
        |-> ##1 filtered_feedback_value_o
            > $past(filtered_feedback_value_o, 2))
        else $error("filtered value did not rise");
    a_sleep_pullup: assert property (burst_sleep_i
        && mode_o == FSF_BURST |=> !feedback_pullup_en_o)
        else $error("pull-up on in burst sleep");
endmodule

bind fsf_filter fsf_filter_asserts #(.FB_W(FB_W)) fsf_filter_asserts_inst (.*);

/* File: sim/tb.sv */
/*
 testbench of the feedback sampling filter.
 assumes the optocoupler model drives the feedback sample input.
*/
`timescale 1ns/1ps
`include "fsf_cfg.svh"

module tb;
    import fsf_pkg::*;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, protect_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic blank_end_i = 1'b0, line_lock_i = 1'b0, dc_input_i = 1'b0;
    logic burst_pulse_i = 1'b0, burst_sleep_i = 1'b0;
    logic halfsine_tick_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00, temp_est_i = 8'h40;
    logic [31:0] pwdata_i = 32'h0, prdata_o, q;
    logic [11:0] vin_est_i = 12'h100, vout_est_i = 12'h000, level = 12'h0;
    logic [11:0] fb_sample_i, filtered_feedback_value_o, mdl = 12'h000;
    logic [9:0]  on_time_o, min_switch_period_o, t10;
    logic [5:0]  burst_pulse_count_o;
    logic [3:0]  valley_o, feedback_pullup_select_o, t4;
    logic [2:0]  phase_o;
    logic [1:0]  mode_o;
    logic        pready_o, pslverr_o, notch_en_o, feedback_pullup_en_o, e;
    int          mismatches = 0, n_tests = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    fsf_filter #(.OPC_CYC(200), .SOFT_CYC(20)) fsf_filter_inst (.*);
    fsf_opto_model fsf_opto_model_inst (.clk_i(clk_sys_i),
        .pullup_en_i(feedback_pullup_en_o), .level_i(level),
        .fb_o(fb_sample_i));

    ////////////////////////////////////////////////////////////////////
    task summarize;
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // request held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys_i);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1) break;
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
        if (i == 20) begin mismatches++; summarize; end
    endtask

    // m=1 watches mode, else phase
    task wait_out(input logic [2:0] v, input bit m, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk_sys_i);
            if ((m ? {1'b0, mode_o} : phase_o) === v) break;
        end
        if (i == lim) begin mismatches++; summarize; end
    endtask

    // level moves away after the strobe: only the strobe may sample
    task samp(input logic [11:0] x, input bit take);
        logic signed [12:0] dd;
        @(posedge clk_sys_i);
        level <= x;
        cyc(2);
        blank_end_i <= 1'b1;
        @(posedge clk_sys_i);
        blank_end_i <= 1'b0; level <= ~x;
        dd = {1'b0, x} - {1'b0, mdl};
        if (take) mdl = mdl + 12'(dd >>> 3);
        cyc(3);
        chk(filtered_feedback_value_o, mdl);
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_regs;
        logic [7:0]  ofs[5];
        logic [31:0] rv[5];
        ofs = '{`FSF_OFS_CTRL, `FSF_OFS_START, `FSF_OFS_VINLIM,
                `FSF_OFS_THR, `FSF_OFS_TEMPLIM};
        rv = '{`FSF_CTRL_RST, `FSF_START_RST, `FSF_VINLIM_RST,
               `FSF_THR_RST, `FSF_TEMPLIM_RST};
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, ofs[k], 32'h0);
            chk(q, rv[k]);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, `FSF_OFS_STATUS, 32'hFFFF_FFFF);
        chk(e, 1'b0);
    endtask

    task t_start;
        apb(1'b1, `FSF_OFS_CTRL, 32'h0000_0051);
        cyc(40);
        chk(phase_o, FSF_IDLE);
        vin_est_i <= 12'h800;
        wait_out(FSF_SOFT, 1'b0, 20);
        wait_out(FSF_CHARGE, 1'b0, 60);
        cyc(30);
        chk(phase_o, FSF_CHARGE);
        vout_est_i <= 12'hD00;
        wait_out(FSF_REG, 1'b0, 20);
    endtask

    task t_filter;
        burst_pulse_i <= 1'b1;
        repeat (24) samp(12'h800, 1'b1);
        wait_out(FSF_VALLEY, 1'b1, 500);
        cyc(500);
        t10 = ~mdl[11:2];
        t4 = 4'hF - mdl[11:8];
        chk(on_time_o, mdl[11:2]);
        chk(min_switch_period_o, t10);
        chk(valley_o, t4);
        dc_input_i <= 1'b1;
        cyc(600);
        chk(notch_en_o, 1'b0);
        for (int i = 0; i < 900 && notch_en_o !== 1'b1; i++) cyc(1);
        chk(notch_en_o, 1'b1);
        // in notch mode a sample waits for the cycle mean
        repeat (2) samp(12'h600, 1'b0);
        cyc(230);
        mdl = 12'h600;
        chk(filtered_feedback_value_o, mdl);
        dc_input_i <= 1'b0;
        cyc(4);
        chk(notch_en_o, 1'b0);
        // locked: the operation cycle waits for half-sine ticks
        line_lock_i <= 1'b1;
        cyc(1300);
        chk(notch_en_o, 1'b0);
        repeat (6) begin
            halfsine_tick_i <= 1'b1;
            cyc(1);
            halfsine_tick_i <= 1'b0;
            cyc(9);
        end
        cyc(4);
        chk(notch_en_o, 1'b1);
        line_lock_i <= 1'b0;
        cyc(4);
        chk(notch_en_o, 1'b0);
        repeat (40) samp(12'h200, 1'b1);
        wait_out(FSF_DCM, 1'b1, 500);
        repeat (40) samp(12'h0C0, 1'b1);
        wait_out(FSF_BURST, 1'b1, 500);
        cyc(250);
        chk(burst_pulse_count_o, mdl[11:6]);
        burst_pulse_i <= 1'b0;
        samp(12'hFFF, 1'b0);
        burst_sleep_i <= 1'b1;
        cyc(3);
        chk(feedback_pullup_en_o, 1'b0);
        burst_sleep_i <= 1'b0;
        cyc(3);
        chk(feedback_pullup_en_o, 1'b1);
        chk(feedback_pullup_select_o, 4'h5);
    endtask

    task t_protect;
        protect_i <= 1'b1;
        wait_out(FSF_FAULT, 1'b0, 10);
        protect_i <= 1'b0;
        wait_out(FSF_IDLE, 1'b0, 10);
    endtask

    // mid-run reset: switching period, valley, phase and control register back to reset values
    task t_reset;
        reset_n_i <= 1'b0;
        cyc(2);
        chk(min_switch_period_o, 10'h3FF);
        chk(valley_o, 4'h1);
        chk(phase_o, FSF_IDLE);
        reset_n_i <= 1'b1;
        apb(1'b0, `FSF_OFS_CTRL, 32'h0);
        chk(q, `FSF_CTRL_RST);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        reset_n_i <= 1'b1;
        t_regs;
        t_start;
        t_filter;
        t_protect;
        t_reset;
        summarize;
    end
endmodule
